/* File: core/btp_cfg.svh */
`ifndef BTP_CFG_SVH
`define BTP_CFG_SVH
// ==========================================================
// clock and conversion of times to cycles
`define BTP_CLK_KHZ          20000
`define BTP_CYC_NS(t)        ((((t) * `BTP_CLK_KHZ) + 999999) / 1000000)
`define BTP_CYC_MS(t)        ((t) * `BTP_CLK_KHZ)
// ==========================================================
// filter and timer durations, least values
`define BTP_T_WARN_NS        1000
`define BTP_T_TSD_NS         1700
`define BTP_T_SDOFF_MS       90
`define BTP_T_SECURE_MS      1500
`define BTP_T_OFFMIN_NS      30000
`define BTP_T_BLANK_NORM_NS  10000
`define BTP_T_BLANK_LOW_NS   15000
`define BTP_T_LIMH_NS        550
`define BTP_T_LIML_NS        2000
// ==========================================================
// command and answer field positions
`define BTP_WARN_LSB         4
`define BTP_SD_LSB           7
`define BTP_SEC_BIT          0
`define BTP_LIVE_SD_BIT      3
`define BTP_LATCH_SD_BIT     2
`define BTP_LATCH_WARN_BIT   5
// ==========================================================
// reset values, codes and widths
`define BTP_WARN_CODE_RST    3'h0
`define BTP_SD_CODE_RST      3'h0
`define BTP_SECURE_RST       1'b0
`define BTP_WARN_BAD_A       3'h2
`define BTP_WARN_BAD_B       3'h3
`define BTP_CNT_W            8
`define BTP_FRAME_W          16
`endif

/* File: core/btp_pkg.sv */
`default_nettype none
package btp_pkg;
`include "btp_cfg.svh"
   // ==========================================================
   // shared types
   typedef enum logic {BTP_RUN, BTP_SHUT} btp_sd_e;
   typedef enum logic [1:0] {BTP_CL_IDLE, BTP_CL_BLANK, BTP_CL_OFF} btp_cl_e;

   // thresholds and option as applied
   typedef struct packed {
      logic [2:0] sd_code;
      logic [2:0] warn_code;
      logic       secure_en;
   } btp_cfg_s;

   // flags seen by the answer frames, plus the shutdown entry count
   typedef struct packed {
      logic                  live_shutdown_n;
      logic                  latched_shutdown_n;
      logic                  latched_warning;
      logic [`BTP_CNT_W-1:0] shutdown_event_count;
   } btp_stat_s;
endpackage
`default_nettype wire

/* File: core/btp_thermal.sv */
// Operation
// - warning offset code in frame 4 bits 6..4; codes 010 and 011 refused
// - shutdown offset code in frame 4 bits 9..7, all eight codes legal
// - applied warning and shutdown codes echoed at same bits in frame 7b
// - over shutdown threshold disables bridge, sets latched and live flag
// - live shutdown flag low while in shutdown, high while bridge active
// - latched shutdown flag, active low, cleared by request, disable, reset
// - count shutdown entries; count clears after it has been read
// - leave shutdown on disable rising edge after release time; count clears
// - current limit derates above the warning threshold toward shutdown limit
// - below warning minus hysteresis the limit returns to first segment
// - secure delay enable in frame 5 bit 0, default off
// - with secure delay, derate only if still hot after the secure time
// - without secure delay, derate as soon as warning is reached
// - secure delay enable echoed in frame 7c bit 0
// - warning held for debounce time sets the latched warning flag
// - latched warning clears by request or disable only when cool, by reset always
// - latched warning active high, default low, in frame 8a
// - minimum off time of 30 to 45 us after current limiting
// - blanking 10 to 15 us at normal supply, 15 to 20 us when low
// - anti-glitch filters on high and low current limit comparators
// - shutdown release filter 90 to 110 ms below release level
// - secure delay lasts 1.5 to 2 s
`default_nettype none
module btp_thermal
   import btp_pkg::*;
#(
   parameter logic [20:0] P_SDOFF_CYC  = 21'(`BTP_CYC_MS(`BTP_T_SDOFF_MS)),
   parameter logic [24:0] P_SECURE_CYC = 25'(`BTP_CYC_MS(`BTP_T_SECURE_MS))
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // command frames from the serial front end (same clock)
   input  wire logic                    frame4_wr,
   input  wire logic [`BTP_FRAME_W-1:0] frame4_data,
   input  wire logic                    frame5_wr,
   input  wire logic [`BTP_FRAME_W-1:0] frame5_data,
   input  wire logic                    diag_clear,
   input  wire logic                    count_read,
   // analog comparators and pins (asynchronous)
   input  wire logic                    tj_over_warn,
   input  wire logic                    tj_below_warn_hyst,
   input  wire logic                    tj_over_sd,
   input  wire logic                    tj_below_sd_hyst,
   input  wire logic                    ilim_high_cmp,
   input  wire logic                    ilim_low_cmp,
   input  wire logic                    vps_above_norm,
   input  wire logic                    pwm_in,
   input  wire logic                    disable_input,
   // answer fields
   output logic [`BTP_FRAME_W-1:0]      frame7b_echo,
   output logic [`BTP_FRAME_W-1:0]      frame7c_echo,
   output logic [`BTP_FRAME_W-1:0]      frame8a_bits,
   output logic [`BTP_FRAME_W-1:0]      frame8b_bits,
   output btp_stat_s                    status,
   output btp_cfg_s                     cfg_applied,
   // bridge and limit control
   output logic                         bridge_disable,
   output logic                         ilim_derate,
   output logic                         ilim_blanking,
   output logic                         ilim_freewheel
);
   // ==========================================================
   // cycle counts derived from the clock rate
   localparam logic [5:0] WARN_CYC = 6'(`BTP_CYC_NS(`BTP_T_WARN_NS));
   localparam logic [5:0] TSD_CYC  = 6'(`BTP_CYC_NS(`BTP_T_TSD_NS));
   localparam logic [9:0] OFF_CYC  = 10'(`BTP_CYC_NS(`BTP_T_OFFMIN_NS));
   localparam logic [8:0] BLK_NORM_CYC =
      9'(`BTP_CYC_NS(`BTP_T_BLANK_NORM_NS));
   localparam logic [8:0] BLK_LOW_CYC  =
      9'(`BTP_CYC_NS(`BTP_T_BLANK_LOW_NS));
   localparam logic [3:0] LIMH_CYC = 4'(`BTP_CYC_NS(`BTP_T_LIMH_NS));
   localparam logic [5:0] LIML_CYC = 6'(`BTP_CYC_NS(`BTP_T_LIML_NS));
   localparam int unsigned NSYNC = 9;

   // ==========================================================
   // input synchronisers
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;
   logic             dis_prev_r;

   assign async_in = {disable_input, pwm_in, vps_above_norm, ilim_low_cmp,
                      ilim_high_cmp, tj_below_sd_hyst, tj_over_sd,
                      tj_below_warn_hyst, tj_over_warn};

   // two flops per pin, the first one read by the second only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   logic s_over_warn;
   logic s_cool_warn;
   logic s_over_sd;
   logic s_cool_sd;
   logic s_lim_hi;
   logic s_lim_lo;
   logic s_vps_norm;
   logic s_pwm;
   logic s_dis;

   assign {s_dis, s_pwm, s_vps_norm, s_lim_lo, s_lim_hi, s_cool_sd,
           s_over_sd, s_cool_warn, s_over_warn} = sync_r;

   // edge of the disable pin, used for release and flag clearing
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dis_prev_r <= 1'b0;
      end else begin
         dis_prev_r <= s_dis;
      end
   end

   logic dis_rise;
   logic flag_clear;

   assign dis_rise   = s_dis && !dis_prev_r;
   assign flag_clear = diag_clear || dis_rise;

   // ==========================================================
   // configuration
   btp_cfg_s   cfg_r;
   logic [2:0] warn_wr;
   logic [2:0] sd_wr;

   assign warn_wr = frame4_data[`BTP_WARN_LSB +: 3];
   assign sd_wr   = frame4_data[`BTP_SD_LSB +: 3];

   // a forbidden warning code leaves the old threshold in force
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_r.warn_code <= `BTP_WARN_CODE_RST;
         cfg_r.sd_code   <= `BTP_SD_CODE_RST;
      end else if (frame4_wr) begin
         if (warn_wr != `BTP_WARN_BAD_A && warn_wr != `BTP_WARN_BAD_B) begin
            cfg_r.warn_code <= warn_wr;
         end
         cfg_r.sd_code <= sd_wr;
      end
   end

   // secure delay option
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_r.secure_en <= `BTP_SECURE_RST;
      end else if (frame5_wr) begin
         cfg_r.secure_en <= frame5_data[`BTP_SEC_BIT];
      end
   end

   assign cfg_applied = cfg_r;

   // ==========================================================
   // filters on temperature comparators
   logic warn_hot;
   logic sd_hot;
   logic release_ok;
   logic secure_done;
   logic in_shut;

   btp_timer #(.W(6)) u_warn_filt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (s_over_warn),
      .limit   (WARN_CYC),
      .done    (warn_hot)
   );

   btp_timer #(.W(6)) u_sd_filt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (s_over_sd),
      .limit   (TSD_CYC),
      .done    (sd_hot)
   );

   // release time only runs while shut down and below release level
   btp_timer #(.W(21)) u_release (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (in_shut && s_cool_sd),
      .limit   (P_SDOFF_CYC),
      .done    (release_ok)
   );

   // secure time runs while hot but not yet at shutdown level
   btp_timer #(.W(25)) u_secure (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (cfg_r.secure_en && s_over_warn && !s_over_sd),
      .limit   (P_SECURE_CYC),
      .done    (secure_done)
   );

   // ==========================================================
   // shutdown state
   btp_sd_e sd_state_r;

   assign in_shut = (sd_state_r == BTP_SHUT);

   // only a disable rising edge after the release time ends it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sd_state_r <= BTP_RUN;
      end else begin
         unique case (sd_state_r)
            BTP_RUN: begin
               if (sd_hot) begin
                  sd_state_r <= BTP_SHUT;
               end
            end
            BTP_SHUT: begin
               if (dis_rise && release_ok) begin
                  sd_state_r <= BTP_RUN;
               end
            end
         endcase
      end
   end

   logic sd_entry;
   logic sd_release;

   assign sd_entry   = (sd_state_r == BTP_RUN) && sd_hot;
   assign sd_release = in_shut && dis_rise && release_ok;

   // live flag follows the state, registered
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status.live_shutdown_n <= 1'b1;
      end else begin
         status.live_shutdown_n <= !(in_shut || sd_entry);
      end
   end

   // latched flag: a new entry beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status.latched_shutdown_n <= 1'b1;
      end else if (sd_entry) begin
         status.latched_shutdown_n <= 1'b0;
      end else if (flag_clear) begin
         status.latched_shutdown_n <= 1'b1;
      end
   end

   // entry counter saturates rather than wrap to a clean zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status.shutdown_event_count <= '0;
      end else if (sd_entry) begin
         if (count_read) begin
            status.shutdown_event_count <= `BTP_CNT_W'(1);
         end else if (status.shutdown_event_count != '1) begin
            status.shutdown_event_count <=
               status.shutdown_event_count + `BTP_CNT_W'(1);
         end
      end else if (count_read || sd_release) begin
         status.shutdown_event_count <= '0;
      end
   end

   // ==========================================================
   // warning flag: clear honoured only once the die is cool
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status.latched_warning <= 1'b0;
      end else if (warn_hot) begin
         status.latched_warning <= 1'b1;
      end else if (flag_clear && !s_over_warn) begin
         status.latched_warning <= 1'b0;
      end
   end

   // ==========================================================
   // temperature dependent current limit segment
   logic derate_req;

   assign derate_req = warn_hot && (!cfg_r.secure_en || secure_done);

   // leave derating only below warning minus hysteresis
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ilim_derate <= 1'b0;
      end else if (derate_req) begin
         ilim_derate <= 1'b1;
      end else if (s_cool_warn) begin
         ilim_derate <= 1'b0;
      end
   end

   // ==========================================================
   // current limit loop: glitch filters, blanking, off time
   logic    hi_seen;
   logic    lo_seen;
   logic    blank_done;
   logic    off_done;
   logic    blank_long_r;
   logic    pwm_prev_r;
   btp_cl_e cl_state_r;

   btp_timer #(.W(4)) u_hi_filt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (s_lim_hi),
      .limit   (LIMH_CYC),
      .done    (hi_seen)
   );

   btp_timer #(.W(6)) u_lo_filt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (s_lim_lo),
      .limit   (LIML_CYC),
      .done    (lo_seen)
   );

   btp_timer #(.W(9)) u_blank (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (cl_state_r == BTP_CL_BLANK),
      .limit   (blank_long_r ? BLK_LOW_CYC : BLK_NORM_CYC),
      .done    (blank_done)
   );

   btp_timer #(.W(10)) u_offmin (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cond    (cl_state_r == BTP_CL_OFF),
      .limit   (OFF_CYC),
      .done    (off_done)
   );

   // supply level sampled once per blanking; later crossings ignored
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         blank_long_r <= 1'b0;
      end else if (cl_state_r == BTP_CL_IDLE && hi_seen) begin
         blank_long_r <= !s_vps_norm;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pwm_prev_r <= 1'b0;
      end else begin
         pwm_prev_r <= s_pwm;
      end
   end

   // a pwm fall during blanking also starts the off time
   always_ff @(posedge clk_sys) begin
      if (!rst_n || in_shut) begin
         cl_state_r <= BTP_CL_IDLE;
      end else begin
         unique case (cl_state_r)
            BTP_CL_IDLE: begin
               if (hi_seen) begin
                  cl_state_r <= BTP_CL_BLANK;
               end
            end
            BTP_CL_BLANK: begin
               if (blank_done || (pwm_prev_r && !s_pwm)) begin
                  cl_state_r <= BTP_CL_OFF;
               end
            end
            BTP_CL_OFF: begin
               if (off_done && lo_seen) begin
                  cl_state_r <= BTP_CL_IDLE;
               end
            end
            default: begin
               cl_state_r <= BTP_CL_IDLE;
            end
         endcase
      end
   end

   assign ilim_blanking  = (cl_state_r == BTP_CL_BLANK);
   assign ilim_freewheel = (cl_state_r == BTP_CL_OFF);
   assign bridge_disable = in_shut;

   // ==========================================================
   // answer fields, codes in the command positions
   always_comb begin
      frame7b_echo = '0;
      frame7b_echo[`BTP_WARN_LSB +: 3] = cfg_r.warn_code;
      frame7b_echo[`BTP_SD_LSB +: 3]   = cfg_r.sd_code;
      frame7c_echo = '0;
      frame7c_echo[`BTP_SEC_BIT] = cfg_r.secure_en;
      frame8a_bits = '0;
      frame8a_bits[`BTP_LATCH_WARN_BIT] = status.latched_warning;
      frame8b_bits = '0;
      frame8b_bits[`BTP_LIVE_SD_BIT]  = status.live_shutdown_n;
      frame8b_bits[`BTP_LATCH_SD_BIT] = status.latched_shutdown_n;
   end
endmodule
`default_nettype wire

/* File: core/btp_timer.sv */
`default_nettype none
// ==========================================================
// qualifying counter: done once cond held for limit cycles
module btp_timer #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output logic              done
);
   logic [W-1:0] cnt_r;

   // restart whenever the condition drops, saturate at the limit
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !cond) begin
         cnt_r <= '0;
      end else if (cnt_r != limit) begin
         cnt_r <= cnt_r + W'(1);
      end
   end

   assign done = cond && (cnt_r == limit);
endmodule
`default_nettype wire

/* File: test/btp_host.sv */
`default_nettype none
// ==========================================================
// controller side: command strobes and the disable pin
module btp_host (
   input  wire logic  clk_sys,
   output logic       frame4_wr,
   output logic [15:0] frame4_data,
   output logic       frame5_wr,
   output logic [15:0] frame5_data,
   output logic       diag_clear,
   output logic       count_read,
   output logic       disable_input
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {frame4_wr, frame5_wr, diag_clear, count_read} = 4'h0;
      {frame4_data, frame5_data} = 32'h0;
      disable_input = 1'b0;
   end
   // one-cycle strobes; data inverted after use so stale values show
   task automatic wr4(input logic [15:0] d);
      @(posedge clk_sys) {frame4_wr, frame4_data} <= {1'b1, d};
      @(posedge clk_sys) {frame4_wr, frame4_data} <= {1'b0, ~d};
   endtask
   task automatic wr5(input logic [15:0] d);
      @(posedge clk_sys) {frame5_wr, frame5_data} <= {1'b1, d};
      @(posedge clk_sys) {frame5_wr, frame5_data} <= {1'b0, ~d};
   endtask
   task automatic clear();
      @(posedge clk_sys) diag_clear <= 1'b1;
      @(posedge clk_sys) diag_clear <= 1'b0;
   endtask
   task automatic rd_count();
      @(posedge clk_sys) count_read <= 1'b1;
      @(posedge clk_sys) count_read <= 1'b0;
   endtask
   // low-to-high on the disable pin, held long enough to be synced
   task automatic dis_rise();
      @(posedge clk_sys) disable_input <= 1'b1;
      repeat (4) @(posedge clk_sys);
      disable_input <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: test/btp_monitor.sv */
`default_nettype none
// ==========================================================
// port checker for the thermal block
module btp_monitor
   import btp_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        frame4_wr,
   input wire logic [15:0] frame4_data,
   input wire logic        tj_over_warn,
   input wire logic        tj_over_sd,
   input wire logic [15:0] frame7b_echo,
   input wire logic [15:0] frame7c_echo,
   input wire logic [15:0] frame8a_bits,
   input wire logic [15:0] frame8b_bits,
   input wire btp_stat_s   status,
   input wire btp_cfg_s    cfg_applied,
   input wire logic        bridge_disable,
   input wire logic        ilim_blanking,
   input wire logic        ilim_freewheel
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] fw_cnt_r;
   logic [9:0] bl_cnt_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // phase length counters; cleared whenever the phase is left
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !ilim_freewheel) fw_cnt_r <= 10'h000;
      else fw_cnt_r <= fw_cnt_r + 10'h001;
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !ilim_blanking) bl_cnt_r <= 10'h000;
      else bl_cnt_r <= bl_cnt_r + 10'h001;
   end
   sequence s_shut_entry;
      $rose(bridge_disable);
   endsequence
   sequence s_warn_entry;
      $rose(status.latched_warning);
   endsequence
   // ==========================================================
   // assertions
   a_sd_code_taken: assert property (frame4_wr |=>
      cfg_applied.sd_code == $past(frame4_data[9:7]))
      else $error("shutdown code not taken");
   a_bad_warn_kept: assert property (
      frame4_wr && frame4_data[6:5] == 2'h1 |=>
      cfg_applied.warn_code == $past(cfg_applied.warn_code))
      else $error("refused warning code was applied");
   a_echo_frame7: assert property (
      frame7b_echo == {6'h00, cfg_applied.sd_code,
         cfg_applied.warn_code, 4'h0} &&
      frame7c_echo[0] == cfg_applied.secure_en)
      else $error("echo differs from applied setting");
   a_flag_bits: assert property (
      frame8b_bits[3:2] == {status.live_shutdown_n,
         status.latched_shutdown_n} &&
      frame8a_bits[5] == status.latched_warning)
      else $error("answer flag bits differ from status");
   a_live_follows: assert property (bridge_disable |->
      !status.live_shutdown_n)
      else $error("live flag high while bridge off");
   a_shut_latches: assert property (s_shut_entry |->
      !status.latched_shutdown_n &&
      status.shutdown_event_count != 8'h00)
      else $error("shutdown entry not recorded");
   a_sd_filter: assert property (s_shut_entry |->
      $past(tj_over_sd, 4) && $past(tj_over_sd, 34))
      else $error("shutdown entered before filter time");
   a_warn_filter: assert property (s_warn_entry |->
      $past(tj_over_warn, 4) && $past(tj_over_warn, 20))
      else $error("warning latched before debounce time");
   a_freewheel_min: assert property (
      $fell(ilim_freewheel) && !bridge_disable |->
      fw_cnt_r >= 10'h258)
      else $error("off time shorter than minimum");
   a_blank_max: assert property (ilim_blanking |->
      bl_cnt_r < 10'h190)
      else $error("blanking longer than maximum");
endmodule
bind btp_thermal btp_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n),
   .frame4_wr(frame4_wr), .frame4_data(frame4_data),
   .tj_over_warn(tj_over_warn), .tj_over_sd(tj_over_sd),
   .frame7b_echo(frame7b_echo), .frame7c_echo(frame7c_echo),
   .frame8a_bits(frame8a_bits), .frame8b_bits(frame8b_bits),
   .status(status), .cfg_applied(cfg_applied),
   .bridge_disable(bridge_disable), .ilim_blanking(ilim_blanking),
   .ilim_freewheel(ilim_freewheel));
`default_nettype wire

/* File: test/tb_btp_thermal.sv */
`default_nettype none
module tb_btp_thermal
   import btp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0, rst_n = 1'b0;
   logic f4w, f5w, dclr, crd, dis;
   logic [15:0] f4d, f5d, e7b, e7c, b8a, b8b;
   logic ow = 1'b0, owh = 1'b1, os = 1'b0, osh = 1'b1;
   logic ihi = 1'b0, ilo = 1'b0, vps = 1'b1, pwm = 1'b0;
   logic brd, der, blk, fwl;
   btp_stat_s st;
   btp_cfg_s  cfg;
   int mismatches = 0, n_tests = 0, cyc_n = 0;
   logic [2:0] wexp;
   always #25 clk_sys = ~clk_sys;
   btp_host i_host (.clk_sys(clk_sys), .frame4_wr(f4w),
      .frame4_data(f4d), .frame5_wr(f5w), .frame5_data(f5d),
      .diag_clear(dclr), .count_read(crd), .disable_input(dis));
   // short release and secure times keep the run brief
   btp_thermal #(.P_SDOFF_CYC(21'h000032), .P_SECURE_CYC(25'h0000050))
   i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .frame4_wr(f4w),
      .frame4_data(f4d), .frame5_wr(f5w), .frame5_data(f5d),
      .diag_clear(dclr), .count_read(crd), .tj_over_warn(ow),
      .tj_below_warn_hyst(owh), .tj_over_sd(os),
      .tj_below_sd_hyst(osh), .ilim_high_cmp(ihi),
      .ilim_low_cmp(ilo), .vps_above_norm(vps), .pwm_in(pwm),
      .disable_input(dis), .frame7b_echo(e7b), .frame7c_echo(e7c),
      .frame8a_bits(b8a), .frame8b_bits(b8b), .status(st),
      .cfg_applied(cfg), .bridge_disable(brd), .ilim_derate(der),
      .ilim_blanking(blk), .ilim_freewheel(fwl));
   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic temp(input logic w, wh, s, sh);
      @(posedge clk_sys) {ow, owh, os, osh} <= {w, wh, s, sh};
   endtask
   task automatic cur(input logic h, l, v);
      @(posedge clk_sys) {ihi, ilo, vps} <= {h, l, v};
   endtask
   task automatic chk_v(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_f(input logic got, exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard, well above the expected length of the run
   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 10000) begin
         mismatches++;
         complete_run();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      cyc(16);
      rst_n <= 1'b1;
      cyc(1);
      chk_v(e7b, 16'h0000);
      chk_v(e7c, 16'h0000);
      chk_f(b8a[5], 1'b0);
      chk_v({13'h0000, st.live_shutdown_n, st.latched_shutdown_n, brd},
         16'h0006);
      wexp = 3'h0;
      // every shutdown code, every warning code, refused ones kept
      for (int i = 0; i < 8; i++) begin
         i_host.wr4({6'h00, 3'(i), 3'(7 - i), 4'h0});
         if (3'(7 - i) != 3'h2 && 3'(7 - i) != 3'h3) wexp = 3'(7 - i);
         cyc(1);
         chk_v(e7b, {6'h00, 3'(i), wexp, 4'h0});
      end
      i_host.wr5(16'h0001);
      cyc(1);
      chk_v(e7c, 16'h0001);
      i_host.wr5(16'h0000);
      cyc(1);
      chk_v(e7c, 16'h0000);
      // warning with a glitch, then held, secure delay off
      temp(1, 0, 0, 1);
      cyc(10);
      temp(0, 1, 0, 1);
      temp(1, 0, 0, 1);
      cyc(12);
      chk_f(st.latched_warning, 1'b0);
      cyc(18);
      chk_f(b8a[5], 1'b1);
      chk_f(der, 1'b1);
      // glitch restarts the filter; a clear while hot is refused
      temp(0, 0, 0, 1);
      temp(1, 0, 0, 1);
      cyc(2);
      i_host.clear();
      cyc(3);
      chk_f(st.latched_warning, 1'b1);
      temp(0, 1, 0, 1);
      cyc(5);
      chk_f(der, 1'b0);
      i_host.clear();
      cyc(3);
      chk_f(st.latched_warning, 1'b0);
      // secure delay on: limit held until the timer runs out
      i_host.wr5(16'h0001);
      temp(1, 0, 0, 1);
      cyc(40);
      chk_f(der, 1'b0);
      cyc(60);
      chk_f(der, 1'b1);
      temp(0, 1, 0, 1);
      i_host.clear();
      i_host.wr5(16'h0000);
      // shutdown, early disable edge ignored, then release
      temp(0, 1, 1, 0);
      cyc(30);
      chk_f(brd, 1'b0);
      cyc(10);
      chk_v({14'h0000, b8b[3:2]}, 16'h0000);
      chk_v({7'h00, brd, st.shutdown_event_count}, 16'h0101);
      temp(0, 1, 0, 1);
      i_host.dis_rise();
      cyc(2);
      chk_f(brd, 1'b1);
      cyc(60);
      i_host.dis_rise();
      cyc(3);
      chk_v({5'h00, brd, st.live_shutdown_n, st.latched_shutdown_n,
         st.shutdown_event_count}, 16'h0300);
      // second shutdown: counter read, flag cleared by request
      temp(0, 1, 1, 0);
      cyc(40);
      chk_v({8'h00, st.shutdown_event_count}, 16'h0001);
      temp(0, 1, 0, 1);
      i_host.rd_count();
      cyc(2);
      chk_v({8'h00, st.shutdown_event_count}, 16'h0000);
      i_host.clear();
      cyc(3);
      chk_v({14'h0000, b8b[3:2]}, 16'h0001);
      cyc(60);
      i_host.dis_rise();
      cyc(3);
      chk_f(brd, 1'b0);
      // current loop: glitch, normal supply, then low supply
      @(posedge clk_sys) pwm <= 1'b1;
      cur(1, 0, 1);
      cyc(5);
      cur(0, 0, 1);
      cyc(15);
      chk_f(blk, 1'b0);
      cur(1, 0, 1);
      cyc(18);
      chk_f(blk, 1'b1);
      cyc(180);
      chk_f(blk, 1'b1);
      cyc(30);
      chk_v({14'h0000, blk, fwl}, 16'h0001);
      cur(0, 1, 1);
      cyc(500);
      chk_f(fwl, 1'b1);
      cyc(150);
      chk_f(fwl, 1'b0);
      cur(1, 0, 0);
      cyc(250);
      chk_f(blk, 1'b1);
      cyc(100);
      chk_v({14'h0000, blk, fwl}, 16'h0001);
      cur(0, 1, 0);
      cyc(700);
      chk_f(fwl, 1'b0);
      // pwm fall during blanking starts the off time early
      cur(1, 0, 1);
      cyc(40);
      @(posedge clk_sys) pwm <= 1'b0;
      cyc(5);
      chk_v({14'h0000, blk, fwl}, 16'h0001);
      cur(0, 1, 1);
      cyc(650);
      chk_f(fwl, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
